/* logic/brx_consts.vh */
// constants for the bit, carry and return instruction executor
`ifndef BRX_CONSTS_VH
`define BRX_CONSTS_VH

// ----------------------------------------
// instruction encodings (10-bit words)
// ----------------------------------------
`define BRX_OP_ROT_RIGHT 10'h01D
`define BRX_OP_CLR_CARRY 10'h006
`define BRX_OP_CLR_PORT_C 10'h28C
`define BRX_OP_CLR_PORT_D 10'h014
`define BRX_OP_SUB_RET 10'h044
`define BRX_OP_SUB_RET_SKIP 10'h045
`define BRX_OP_INT_RET 10'h046
// clear memory bit: base with j in bits 1:0
`define BRX_OP_CLR_BIT_BASE 10'h04C
`define BRX_OP_CLR_BIT_MASK 10'h3FC

// ----------------------------------------
// widths and sizes
// ----------------------------------------
`define BRX_PC_W 13
`define BRX_SP_W 3
`define BRX_STACK_DEPTH 8
`define BRX_PORT_D_W 8

// ----------------------------------------
// apb register byte offsets
// ----------------------------------------
`define BRX_ADDR_ACC 12'h000
`define BRX_ADDR_FLAGS 12'h004
`define BRX_ADDR_POINTER 12'h008
`define BRX_ADDR_PORTS 12'h00C
`define BRX_ADDR_STACK_IDX 12'h010
`define BRX_ADDR_STACK_DATA 12'h014

// ----------------------------------------
// field positions
// ----------------------------------------
`define BRX_FLG_CARRY 0
`define BRX_FLG_SKIP 1
`define BRX_FLG_NOP 2
`define BRX_FLG_SUPPR 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define BRX_RST_NIBBLE 4'h0
`define BRX_RST_PORT_D 8'hFF
`define BRX_RST_PORT_C 1'b1

`endif

/* logic/brx_exec.v */
// execution logic for the rotate, reset-bit, reset-carry/port and return instructions
// Operation
// RL1 - rotate right shifts acc, one cycle, updates carry
// RL2 - old carry into msb, lsb into carry
// RL3 - clear memory bit j at data pointer
// RL4 - clear port d bit chosen by y
// RL5 - return: pc from stack, index minus one
// RL6 - return with skip: same, then skip next
// RL7 - interrupt return: pc from stack, one cycle
// RL8 - interrupt return restores x, y, z
// RL9 - interrupt return restores skip, nop, suppress status
// RL10 - interrupt return restores registers a and b
// RL11 - clear carry only, one cycle
// RL12 - clear port c, carry left cleared
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "brx_consts.vh"

module brx_exec
(
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // instruction stream from the core
    input wire i_instr_valid,
    input wire [9:0] i_instr,
    output wire o_instr_ready,
    // interrupt acceptance and subroutine call from the core
    input wire i_intr_accept,
    input wire i_call_valid,
    input wire [`BRX_PC_W-1:0] i_call_pc,
    // program counter and skip towards the core
    output reg o_pc_load,
    output reg [`BRX_PC_W-1:0] o_pc,
    output reg o_skip_next,
    // data memory nibble at the data pointer
    input wire [3:0] i_mem_rdata,
    output reg o_mem_we,
    output reg [3:0] o_mem_wdata,
    // ports
    output wire o_port_c,
    output wire [`BRX_PORT_D_W-1:0] o_port_d,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr
);

    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE = 1'b0; // ready for next instruction
    localparam ST_RET2 = 1'b1; // second cycle of a two-cycle return

    // ----------------------------------------
    // state registers
    // ----------------------------------------
    reg state_reg, state_next; // sequencer state
    reg ret_skip_reg, ret_skip_next; // return in progress skips next
    reg [3:0] acc_reg, acc_next; // register a
    reg [3:0] regb_reg, regb_next; // register b
    reg carry_flag_reg, carry_flag_next; // carry
    reg skip_reg, skip_next; // pending skip status
    reg nop_reg, nop_next; // no-operation mode status
    reg suppr_reg, suppr_next; // load_acc_op / load_pointer_pair_op suppression
    reg [3:0] ptr_x_reg, ptr_x_next; // data_pointer x
    reg [3:0] ptr_y_reg, ptr_y_next; // data_pointer y
    reg [1:0] ptr_z_reg, ptr_z_next; // data_pointer z
    reg port_c_reg, port_c_next; // port c output
    reg [`BRX_PORT_D_W-1:0] port_d_reg, port_d_next; // port d outputs
    reg [`BRX_SP_W-1:0] stack_index_reg, stack_index_next; // stack pointer
    reg [`BRX_PC_W-1:0] stack_entry_reg [0:`BRX_STACK_DEPTH-1]; // return addresses
    reg stk_we; // write one stack entry
    reg [`BRX_SP_W-1:0] stk_widx; // which entry
    reg [`BRX_PC_W-1:0] stk_wdata; // value written
    // interrupt save copies
    reg [3:0] sv_acc_reg, sv_regb_reg, sv_x_reg, sv_y_reg; // saved a, b, x, y
    reg [1:0] sv_z_reg; // saved z
    reg sv_skip_reg, sv_nop_reg, sv_suppr_reg; // saved status bits

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire exec = i_instr_valid && (state_reg == ST_IDLE); // instruction taken
    wire is_clr_bit = (i_instr & `BRX_OP_CLR_BIT_MASK) == `BRX_OP_CLR_BIT_BASE; // clear_mem_bit_op
    wire [1:0] bit_j = i_instr[1:0]; // immediate bit number
    wire [`BRX_PC_W-1:0] top_entry = stack_entry_reg[stack_index_reg]; // stack_entry at index
    // apb access phase, zero wait states
    wire apb_acc = i_psel && i_penable;
    wire apb_wr = apb_acc && i_pwrite;
    wire addr_ok = (i_paddr == `BRX_ADDR_ACC) || (i_paddr == `BRX_ADDR_FLAGS) ||
                   (i_paddr == `BRX_ADDR_POINTER) || (i_paddr == `BRX_ADDR_PORTS) ||
                   (i_paddr == `BRX_ADDR_STACK_IDX) || (i_paddr == `BRX_ADDR_STACK_DATA);
    assign o_pready = 1'b1;
    assign o_pslverr = apb_acc && !addr_ok;
    assign o_instr_ready = (state_reg == ST_IDLE);
    assign o_port_c = port_c_reg;
    assign o_port_d = port_d_reg;
    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    // software writes first, the executing instruction overrides them
    always @*
    begin
        state_next = state_reg;
        ret_skip_next = ret_skip_reg;
        acc_next = acc_reg;
        regb_next = regb_reg;
        carry_flag_next = carry_flag_reg;
        skip_next = skip_reg;
        nop_next = nop_reg;
        suppr_next = suppr_reg;
        ptr_x_next = ptr_x_reg;
        ptr_y_next = ptr_y_reg;
        ptr_z_next = ptr_z_reg;
        port_c_next = port_c_reg;
        port_d_next = port_d_reg;
        stack_index_next = stack_index_reg;
        stk_we = 1'b0;
        stk_widx = stack_index_reg;
        stk_wdata = i_call_pc;
        // register writes from software
        if (apb_wr)
        begin
            case (i_paddr)
                `BRX_ADDR_ACC:
                begin
                    acc_next = i_pwdata[3:0];
                    regb_next = i_pwdata[7:4];
                end
                `BRX_ADDR_FLAGS:
                begin
                    carry_flag_next = i_pwdata[`BRX_FLG_CARRY];
                    skip_next = i_pwdata[`BRX_FLG_SKIP];
                    nop_next = i_pwdata[`BRX_FLG_NOP];
                    suppr_next = i_pwdata[`BRX_FLG_SUPPR];
                end
                `BRX_ADDR_POINTER:
                begin
                    ptr_x_next = i_pwdata[3:0];
                    ptr_y_next = i_pwdata[7:4];
                    ptr_z_next = i_pwdata[9:8];
                end
                `BRX_ADDR_PORTS:
                begin
                    port_c_next = i_pwdata[0];
                    port_d_next = i_pwdata[15:8];
                end
                `BRX_ADDR_STACK_IDX: stack_index_next = i_pwdata[`BRX_SP_W-1:0];
                `BRX_ADDR_STACK_DATA:
                begin
                    stk_we = 1'b1;
                    stk_wdata = i_pwdata[`BRX_PC_W-1:0];
                end
                default: ; // unmapped: no effect
            endcase
        end
        // subroutine call pushes a return address
        if (i_call_valid)
        begin
            stack_index_next = stack_index_reg + 1'b1;
            stk_we = 1'b1;
            stk_widx = stack_index_reg + 1'b1;
            stk_wdata = i_call_pc;
        end
        // instruction execution
        case (state_reg)
            ST_IDLE:
            begin
                if (exec)
                begin
                    if (is_clr_bit)
                        ; // memory write handled in output logic // see RL3
                    else
                    begin
                        case (i_instr)
                            `BRX_OP_ROT_RIGHT:
                            begin
                                acc_next = {carry_flag_reg, acc_reg[3:1]}; // see RL1 // see RL2
                                carry_flag_next = acc_reg[0]; // see RL2
                            end
                            `BRX_OP_CLR_CARRY: carry_flag_next = 1'b0; // see RL11
                            `BRX_OP_CLR_PORT_C:
                            begin
                                port_c_next = 1'b0; // see RL12
                                carry_flag_next = 1'b0; // see RL12
                            end
                            `BRX_OP_CLR_PORT_D:
                            begin
                                if (ptr_y_reg <= 4'h7)
                                    port_d_next[ptr_y_reg[2:0]] = 1'b0; // see RL4
                            end
                            `BRX_OP_SUB_RET, `BRX_OP_SUB_RET_SKIP:
                            begin
                                state_next = ST_RET2; // see RL5 // see RL6
                                ret_skip_next = i_instr[0];
                            end
                            `BRX_OP_INT_RET:
                            begin
                                stack_index_next = stack_index_reg - 1'b1; // see RL7
                                ptr_x_next = sv_x_reg; // see RL8
                                ptr_y_next = sv_y_reg; // see RL8
                                ptr_z_next = sv_z_reg; // see RL8
                                skip_next = sv_skip_reg; // see RL9
                                nop_next = sv_nop_reg; // see RL9
                                suppr_next = sv_suppr_reg; // see RL9
                                acc_next = sv_acc_reg; // see RL10
                                regb_next = sv_regb_reg; // see RL10
                            end
                            default: ; // other instructions belong elsewhere
                        endcase
                    end
                end
            end
            ST_RET2:
            begin
                stack_index_next = stack_index_reg - 1'b1; // see RL5 // see RL6
                ret_skip_next = 1'b0;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end
    // ----------------------------------------
    // clocked state
    // ----------------------------------------
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_reg <= ST_IDLE;
            ret_skip_reg <= 1'b0;
            acc_reg <= `BRX_RST_NIBBLE;
            regb_reg <= `BRX_RST_NIBBLE;
            carry_flag_reg <= 1'b0;
            skip_reg <= 1'b0;
            nop_reg <= 1'b0;
            suppr_reg <= 1'b0;
            ptr_x_reg <= `BRX_RST_NIBBLE;
            ptr_y_reg <= `BRX_RST_NIBBLE;
            ptr_z_reg <= 2'h0;
            port_c_reg <= `BRX_RST_PORT_C;
            port_d_reg <= `BRX_RST_PORT_D;
            stack_index_reg <= {`BRX_SP_W{1'b0}};
        end
        else
        begin
            state_reg <= state_next;
            ret_skip_reg <= ret_skip_next;
            acc_reg <= acc_next;
            regb_reg <= regb_next;
            carry_flag_reg <= carry_flag_next;
            skip_reg <= skip_next;
            nop_reg <= nop_next;
            suppr_reg <= suppr_next;
            ptr_x_reg <= ptr_x_next;
            ptr_y_reg <= ptr_y_next;
            ptr_z_reg <= ptr_z_next;
            port_c_reg <= port_c_next;
            port_d_reg <= port_d_next;
            stack_index_reg <= stack_index_next;
        end
    end
    // ----------------------------------------
    // stack storage, one entry per loop pass
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `BRX_STACK_DEPTH; gi = gi + 1)
        begin : g_stack
            always @(posedge i_clk)
            begin
                if (!i_rst_n)
                    stack_entry_reg[gi] <= {`BRX_PC_W{1'b0}};
                else if (stk_we && (stk_widx == gi))
                    stack_entry_reg[gi] <= stk_wdata;
            end
        end
    endgenerate
    // ----------------------------------------
    // interrupt save copies
    // ----------------------------------------
    // snapshot taken on the cycle the core accepts an interrupt
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            sv_acc_reg <= `BRX_RST_NIBBLE;
            sv_regb_reg <= `BRX_RST_NIBBLE;
            sv_x_reg <= `BRX_RST_NIBBLE;
            sv_y_reg <= `BRX_RST_NIBBLE;
            sv_z_reg <= 2'h0;
            sv_skip_reg <= 1'b0;
            sv_nop_reg <= 1'b0;
            sv_suppr_reg <= 1'b0;
        end
        else if (i_intr_accept)
        begin
            sv_acc_reg <= acc_reg;
            sv_regb_reg <= regb_reg;
            sv_x_reg <= ptr_x_reg;
            sv_y_reg <= ptr_y_reg;
            sv_z_reg <= ptr_z_reg;
            sv_skip_reg <= skip_reg;
            sv_nop_reg <= nop_reg;
            sv_suppr_reg <= suppr_reg;
        end
    end
    // ----------------------------------------
    // outputs to the core and memory
    // ----------------------------------------
    // pc load pulses: first return cycle, or interrupt return
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_pc_load <= 1'b0;
            o_pc <= {`BRX_PC_W{1'b0}};
            o_skip_next <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_wdata <= 4'h0;
        end
        else
        begin
            o_pc_load <= 1'b0;
            o_skip_next <= 1'b0;
            o_mem_we <= 1'b0;
            if (exec && is_clr_bit)
            begin
                o_mem_we <= 1'b1; // see RL3
                o_mem_wdata <= i_mem_rdata & ~(4'h1 << bit_j); // see RL3
            end
            if (exec && ((i_instr == `BRX_OP_SUB_RET) || (i_instr == `BRX_OP_SUB_RET_SKIP) ||
                         (i_instr == `BRX_OP_INT_RET)))
            begin
                o_pc_load <= 1'b1; // see RL5 // see RL7
                o_pc <= top_entry; // see RL5 // see RL7
            end
            if (state_reg == ST_RET2)
                o_skip_next <= ret_skip_reg; // see RL6
        end
    end
    // ----------------------------------------
    // apb read data
    // ----------------------------------------
    always @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_prdata <= 32'h00000000;
        else if (i_psel && !i_penable && !i_pwrite)
        begin
            case (i_paddr)
                `BRX_ADDR_ACC: o_prdata <= {24'h000000, regb_reg, acc_reg};
                `BRX_ADDR_FLAGS: o_prdata <= {28'h0000000, suppr_reg, nop_reg, skip_reg, carry_flag_reg};
                `BRX_ADDR_POINTER: o_prdata <= {22'h000000, ptr_z_reg, ptr_y_reg, ptr_x_reg};
                `BRX_ADDR_PORTS: o_prdata <= {16'h0000, port_d_reg, 7'h00, port_c_reg};
                `BRX_ADDR_STACK_IDX: o_prdata <= {29'h00000000, stack_index_reg};
                `BRX_ADDR_STACK_DATA: o_prdata <= {19'h00000, top_entry};
                default: o_prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // brx_exec

/* testbench/brx_mem_model.sv */
// data memory nibble at the data pointer, as seen by the executor
`timescale 1ns/1ns

module brx_mem_model
#(
    parameter [3:0] INIT = 4'hF // starting nibble contents
)
(
    // clock
    input wire i_clk,
    // write back from the executor
    input wire i_we,
    input wire [3:0] i_wdata,
    // nibble presented to the executor
    output logic [3:0] o_rdata
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    // one nibble; written only on the executor's write pulse
    initial o_rdata = INIT;
    always @(posedge i_clk)
    begin
        if (i_we)
            o_rdata <= i_wdata;
    end
endmodule // brx_mem_model

/* testbench/brx_exec_properties.sv */
// concurrent checks on the executor's ports
`timescale 1ns/1ns
`include "brx_consts.vh"

module brx_exec_properties
(
    input wire i_clk,
    input wire i_rst_n,
    input wire i_instr_valid,
    input wire [9:0] i_instr,
    input wire o_instr_ready,
    input wire o_pc_load,
    input wire o_skip_next,
    input wire [3:0] i_mem_rdata,
    input wire o_mem_we,
    input wire [3:0] o_mem_wdata,
    input wire o_port_c,
    input wire [`BRX_PORT_D_W-1:0] o_port_d
);
    // ----------------------------------------
    // decoded taken instructions
    // ----------------------------------------
    wire taken = i_instr_valid && o_instr_ready;
    wire t_ret = taken && (i_instr == `BRX_OP_SUB_RET || i_instr == `BRX_OP_SUB_RET_SKIP);
    wire t_skip = taken && (i_instr == `BRX_OP_SUB_RET_SKIP);
    wire t_iret = taken && (i_instr == `BRX_OP_INT_RET);
    wire t_bit = taken && ((i_instr & `BRX_OP_CLR_BIT_MASK) == `BRX_OP_CLR_BIT_BASE);
    wire t_pc = taken && (i_instr == `BRX_OP_CLR_PORT_C);
    wire t_pd = taken && (i_instr == `BRX_OP_CLR_PORT_D);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // ----------------------------------------
    // return sequences
    // ----------------------------------------
    // two-cycle return: reload, then ready again
    sequence s_ret_body;
        (o_pc_load && !o_instr_ready) ##1 o_instr_ready;
    endsequence
    // skip pulse lands in the third cycle, two after the return is taken
    sequence s_skip_body;
        !o_skip_next ##1 o_skip_next;
    endsequence

    a_ret_two_cycles: assert property (t_ret |=> s_ret_body) else $error("return not two cycles");
    a_skip_after_ret: assert property (t_skip |=> s_skip_body) else $error("skip pulse missing");
    a_skip_has_cause: assert property (o_skip_next |-> $past(t_skip, 2)) else $error("stray skip pulse");
    a_iret_one_cycle: assert property (t_iret |=> o_pc_load && o_instr_ready && !o_skip_next)
        else $error("interrupt return not one cycle");
    a_pc_load_cause: assert property (o_pc_load |-> $past(t_ret) || $past(t_iret))
        else $error("stray pc reload");
    a_bit_clear_data: assert property (t_bit |=> o_mem_we
        && o_mem_wdata == ($past(i_mem_rdata) & ~(4'h1 << $past(i_instr[1:0]))))
        else $error("memory bit clear wrong");
    a_mem_we_cause: assert property (o_mem_we |-> $past(t_bit)) else $error("stray memory write");
    a_port_c_low: assert property (t_pc |=> !o_port_c) else $error("port c not cleared");
    a_port_d_one_bit: assert property (t_pd |=> ((o_port_d & ~$past(o_port_d)) == 8'h00)
        && $countones(o_port_d ^ $past(o_port_d)) <= 1) else $error("port d clear touched wrong bits");
endmodule // brx_exec_properties

bind brx_exec brx_exec_properties i_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_pc_load(o_pc_load), .o_skip_next(o_skip_next),
    .i_mem_rdata(i_mem_rdata), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_port_c(o_port_c),
    .o_port_d(o_port_d));

/* testbench/bit_carry_return_instr_exec_tb_top.sv */
// self-checking bench for the executor: apb and instruction tasks
`timescale 1ns/1ns
`include "brx_consts.vh"

module bit_carry_return_instr_exec_tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic i_clk = 0, i_rst_n = 0, i_instr_valid = 0, i_intr_accept = 0, i_call_valid = 0;
    logic [9:0] i_instr = 10'h000;
    logic [`BRX_PC_W-1:0] i_call_pc = 13'h0000, o_pc, last_pc = 13'h0000;
    logic i_psel = 0, i_penable = 0, i_pwrite = 0, o_pready, o_pslverr, o_pc_load, o_skip_next, o_instr_ready;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [3:0] mem_nib, o_mem_wdata;
    logic o_mem_we, o_port_c, err;
    logic [7:0] o_port_d, exp_d;
    int num_errors = 0, checks = 0, cycles = 0, skips = 0;

    brx_exec i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
        .o_instr_ready(o_instr_ready), .i_intr_accept(i_intr_accept), .i_call_valid(i_call_valid),
        .i_call_pc(i_call_pc), .o_pc_load(o_pc_load), .o_pc(o_pc), .o_skip_next(o_skip_next),
        .i_mem_rdata(mem_nib), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_port_c(o_port_c),
        .o_port_d(o_port_d), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));
    brx_mem_model #(.INIT(4'hF)) i_mem (.i_clk(i_clk), .i_we(o_mem_we), .i_wdata(o_mem_wdata), .o_rdata(mem_nib));

    // ----------------------------------------
    // clock, monitor and timeout
    // ----------------------------------------
    initial forever #4 i_clk = ~i_clk;
    // record reload targets and skip pulses; cut a hang short
    always @(posedge i_clk)
    begin
        if (o_pc_load) last_pc <= o_pc;
        if (o_skip_next) skips <= skips + 1;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer: setup, access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1; i_penable <= 0; i_pwrite <= wr; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata; err = o_pslverr;
        i_psel <= 0; i_penable <= 0;
    endtask
    // one instruction, held until taken, then let a return finish
    task automatic exec(input logic [9:0] w);
        @(posedge i_clk);
        i_instr_valid <= 1; i_instr <= w;
        do @(posedge i_clk); while (o_instr_ready !== 1'b1);
        i_instr_valid <= 0;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic pulse_call(input logic [12:0] pc);
        @(posedge i_clk);
        i_call_valid <= 1; i_call_pc <= pc;
        @(posedge i_clk);
        i_call_valid <= 0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1;
        apb(0, `BRX_ADDR_PORTS, 0); chk("ports reset", 32'h0000FF01, rd);
        apb(0, 12'h020, 0); chk("unmapped err", 1, err);
        // rotate twice through carry
        apb(1, `BRX_ADDR_ACC, 32'h5); apb(1, `BRX_ADDR_FLAGS, 32'h1);
        exec(`BRX_OP_ROT_RIGHT); apb(0, `BRX_ADDR_ACC, 0); chk("rot acc", 32'hA, rd);
        apb(0, `BRX_ADDR_FLAGS, 0); chk("rot carry", 32'h1, rd);
        exec(`BRX_OP_ROT_RIGHT); apb(0, `BRX_ADDR_ACC, 0); chk("rot acc 2", 32'hD, rd);
        apb(0, `BRX_ADDR_FLAGS, 0); chk("rot carry 2", 32'h0, rd);
        // clear carry leaves acc alone
        apb(1, `BRX_ADDR_ACC, 32'h37); apb(1, `BRX_ADDR_FLAGS, 32'h1); exec(`BRX_OP_CLR_CARRY);
        apb(0, `BRX_ADDR_FLAGS, 0); chk("clr carry", 32'h0, rd);
        apb(0, `BRX_ADDR_ACC, 0); chk("clr carry acc", 32'h37, rd);
        // clear port c also clears carry
        apb(1, `BRX_ADDR_FLAGS, 32'h1); exec(`BRX_OP_CLR_PORT_C);
        apb(0, `BRX_ADDR_PORTS, 0); chk("port c", 32'h0000FF00, rd);
        apb(0, `BRX_ADDR_FLAGS, 0); chk("port c carry", 32'h0, rd);
        // port d bits by y, then two out-of-range y values (8 and 9)
        exp_d = 8'hFF;
        for (int y = 0; y < 10; y++)
        begin
            apb(1, `BRX_ADDR_POINTER, y << 4); exec(`BRX_OP_CLR_PORT_D);
            if (y < 8) exp_d[y] = 1'b0;
            chk("port d", {24'h0, exp_d}, {24'h0, o_port_d});
        end
        // clear memory bits one by one
        for (int j = 0; j < 4; j++)
        begin
            exec(`BRX_OP_CLR_BIT_BASE | j);
            chk("mem bit", 32'hF & ~((32'h2 << j) - 1), {28'h0, mem_nib});
        end
        // plain return and return with skip
        apb(1, `BRX_ADDR_STACK_IDX, 32'h2); pulse_call(13'h1234);
        apb(0, `BRX_ADDR_STACK_DATA, 0); chk("stack data", 32'h1234, rd);
        exec(`BRX_OP_SUB_RET);
        chk("ret pc", 32'h1234, last_pc);
        apb(0, `BRX_ADDR_STACK_IDX, 0); chk("ret idx", 32'h2, rd);
        pulse_call(13'h0ABC); exec(`BRX_OP_SUB_RET_SKIP);
        chk("skip pc", 32'h0ABC, last_pc);
        apb(0, `BRX_ADDR_STACK_IDX, 0); chk("skip idx", 32'h2, rd);
        chk("skip count", 1, skips);
        // interrupt: snapshot, disturb, return
        apb(1, `BRX_ADDR_ACC, 32'h5A); apb(1, `BRX_ADDR_FLAGS, 32'hE); apb(1, `BRX_ADDR_POINTER, 32'h2C3);
        @(posedge i_clk); i_intr_accept <= 1; @(posedge i_clk); i_intr_accept <= 0;
        apb(1, `BRX_ADDR_ACC, 0); apb(1, `BRX_ADDR_FLAGS, 0); apb(1, `BRX_ADDR_POINTER, 0);
        pulse_call(13'h0777); exec(`BRX_OP_INT_RET);
        chk("iret pc", 32'h0777, last_pc);
        apb(0, `BRX_ADDR_STACK_IDX, 0); chk("iret idx", 32'h2, rd);
        apb(0, `BRX_ADDR_POINTER, 0); chk("iret ptr", 32'h2C3, rd);
        apb(0, `BRX_ADDR_FLAGS, 0); chk("iret status", 32'hE, rd);
        apb(0, `BRX_ADDR_ACC, 0); chk("iret a b", 32'h5A, rd);
        print_verdict();
    end
endmodule // bit_carry_return_instr_exec_tb_top
